//--- hdl/tx_map_defs.vh
/*
 * Constants for the transmit field mapper: register offsets, control
 * field positions, reset values, width codes and bit positions on the
 * 44-bit per-channel transmit bus.
 * Assumes inclusion by bare name from the design file.
 */
// How it works
// [RL1] transmit bus is 44 bits per channel
// [RL2] 8-bit width: data byte on bits 7:0
// [RL3] 8-bit 8B/10B: control flag on bit 8
// [RL4] 8-bit: bit 9 force-disparity, PIPE uses compliance
// [RL5] 8-bit non-PIPE: bit 10 forced disparity value
// [RL6] 8-bit PCIe: bit 10 electrical idle force
// [RL7] 10-bit width: whole symbol on bits 9:0
// [RL8] 16-bit, PCS 16/20: bytes at 7:0, 18:11
// [RL9] 16-bit, PCS 16/20: control flags bits 8, 19
// [RL10] 16-bit, PCS 16/20: force enables bits 9, 20
// [RL11] 16-bit, PCS 16/20: disparity values bits 10, 21
// [RL12] 16-bit, PCS 8/10: bytes at 7:0, 29:22
// [RL13] 16-bit, PCS 8/10: control flags bits 8, 30
// [RL14] 16-bit, PCS 8/10 non-PIPE: 9,31 and 10,32
// [RL15] 16-bit, PCS 8/10 PIPE: bit9 compliance, bit31 zero
// [RL16] 16-bit, PCS 8/10 PCIe: idle on 10 and 32
// [RL17] 20-bit, PCS 20: symbols at 9:0, 20:11
// [RL18] 20-bit, PCS 10: symbols at 9:0, 31:22
// [RL19] unassigned transmit bus bits driven to zero
`ifndef TX_MAP_DEFS_VH
`define TX_MAP_DEFS_VH

`define TXM_BUS_W 44
// register byte offsets
`define TXM_OFS_CTRL 12'h000
`define TXM_OFS_STAT 12'h004
`define TXM_OFS_CNT 12'h008
// control register fields
`define TXM_CTRL_WID_LO 0
`define TXM_CTRL_WID_HI 1
`define TXM_CTRL_PCS 2
`define TXM_CTRL_ENC 3
`define TXM_CTRL_PIPE 4
`define TXM_CTRL_RST 5'h00
// interface width codes
`define TXM_WID_8 2'h0
`define TXM_WID_10 2'h1
`define TXM_WID_16 2'h2
`define TXM_WID_20 2'h3
// bus positions, low lane
`define TXM_LO_CTL 8
`define TXM_LO_FRC 9
`define TXM_LO_DSP 10
// bus positions, high lane, PCS 16/20
`define TXM_HW_BASE 11
`define TXM_HW_CTL 19
`define TXM_HW_FRC 20
`define TXM_HW_DSP 21
// bus positions, high lane, PCS 8/10
`define TXM_HN_BASE 22
`define TXM_HN_CTL 30
`define TXM_HN_FRC 31
`define TXM_HN_DSP 32
// fifo word fields
`define TXM_FW 28
`define TXM_F_DLO 0
`define TXM_F_DHI 10
`define TXM_F_CLO 20
`define TXM_F_CHI 21
`define TXM_F_FLO 22
`define TXM_F_FHI 23
`define TXM_F_VLO 24
`define TXM_F_VHI 25
`define TXM_F_IDL 26
`define TXM_F_CMP 27
`define TXM_FIFO_DEPTH 16

`endif

//--- hdl/tx_fabric_bus_field_mapper.v
/*
 * Transmit field mapper: takes per-word transmit fields from fabric logic
 * through a 16-word FIFO, places them on the 44-bit transmit bus by the
 * interface width, PCS-PMA width and encoding mode set over APB.
 * Assumes APB master on mclk, downstream sink with valid/ready.
 */
`include "tx_map_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// synchronous fifo, registered full and empty flags
module tx_map_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire mclk,
    input wire nrst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    reg full_q;
    reg empty_q;
    wire push;
    wire pop;
    wire [AW:0] countNext;

    assign inReady = ~full_q;
    assign outValid = ~empty_q;
    assign outData = mem[rdPtr_q];
    assign level = count_q;
    assign push = inValid & ~full_q;
    assign pop = outReady & ~empty_q;
    assign countNext = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // storage write
    always @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // pointers and flags
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == DEPTH - 1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == DEPTH - 1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
            end
            count_q <= countNext;
            full_q <= (countNext == DEPTH);
            empty_q <= (countNext == {(AW+1){1'b0}});
        end
    end
endmodule // tx_map_fifo

// top: apb registers, fifo and field placement
module tx_fabric_bus_field_mapper #(
    parameter DEPTH = `TXM_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire mclk,
    input wire nrst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // fabric word input
    input wire wordValid,
    output wire wordReady,
    input wire [9:0] dataLo,
    input wire [9:0] dataHi,
    input wire ctrlLo,
    input wire ctrlHi,
    input wire forceDispLo,
    input wire forceDispHi,
    input wire dispValLo,
    input wire dispValHi,
    input wire complianceForce,
    input wire elecIdleForce,
    // transmit bus toward the channel
    output reg [`TXM_BUS_W-1:0] txFull,
    output reg txValid,
    input wire txReady
);
    reg [4:0] ctrl_q;
    reg [31:0] sent_q;
    wire [`TXM_FW-1:0] fifoIn;
    wire [`TXM_FW-1:0] f;
    wire fifoValid;
    wire [AW:0] fifoLevel;
    wire loadStage;
    wire [1:0] wid;
    wire pcsWide;
    wire enc;
    wire pipe;
    wire apbAccess;
    wire mapped;
    reg [`TXM_BUS_W-1:0] mapBus;
    reg [31:0] readVal;

    assign wid = ctrl_q[`TXM_CTRL_WID_HI:`TXM_CTRL_WID_LO];
    assign pcsWide = ctrl_q[`TXM_CTRL_PCS];
    assign enc = ctrl_q[`TXM_CTRL_ENC];
    assign pipe = ctrl_q[`TXM_CTRL_PIPE];

    // pack fabric fields into one fifo word
    assign fifoIn = {complianceForce, elecIdleForce, dispValHi, dispValLo, forceDispHi,
        forceDispLo, ctrlHi, ctrlLo, dataHi, dataLo};

    tx_map_fifo #(
        .WIDTH(`TXM_FW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) wordFifo (
        .mclk(mclk),
        .nrst(nrst),
        .inValid(wordValid),
        .inReady(wordReady),
        .inData(fifoIn),
        .outValid(fifoValid),
        .outReady(loadStage),
        .outData(f),
        .level(fifoLevel)
    );

    // output stage takes a word when empty or being drained
    assign loadStage = fifoValid & (~txValid | txReady);

    // field placement; everything not assigned stays zero [RL19]
    always @* begin
        mapBus = {`TXM_BUS_W{1'b0}}; // [RL1] [RL19]
        case (wid)
            `TXM_WID_8: begin
                mapBus[7:0] = f[`TXM_F_DLO +: 8]; // [RL2]
                if (enc) begin
                    mapBus[`TXM_LO_CTL] = f[`TXM_F_CLO]; // [RL3]
                    mapBus[`TXM_LO_FRC] = pipe ? complianceBit(f) : f[`TXM_F_FLO]; // [RL4]
                    mapBus[`TXM_LO_DSP] = pipe ? f[`TXM_F_IDL] : f[`TXM_F_VLO]; // [RL5] [RL6]
                end
            end
            `TXM_WID_10: begin
                mapBus[9:0] = f[`TXM_F_DLO +: 10]; // [RL7]
            end
            `TXM_WID_16: begin
                mapBus[7:0] = f[`TXM_F_DLO +: 8];
                if (pcsWide) begin
                    mapBus[`TXM_HW_BASE +: 8] = f[`TXM_F_DHI +: 8]; // [RL8]
                    if (enc) begin
                        mapBus[`TXM_LO_CTL] = f[`TXM_F_CLO]; // [RL9]
                        mapBus[`TXM_HW_CTL] = f[`TXM_F_CHI]; // [RL9]
                        mapBus[`TXM_LO_FRC] = f[`TXM_F_FLO]; // [RL10]
                        mapBus[`TXM_HW_FRC] = f[`TXM_F_FHI]; // [RL10]
                        mapBus[`TXM_LO_DSP] = f[`TXM_F_VLO]; // [RL11]
                        mapBus[`TXM_HW_DSP] = f[`TXM_F_VHI]; // [RL11]
                    end
                end else begin
                    mapBus[`TXM_HN_BASE +: 8] = f[`TXM_F_DHI +: 8]; // [RL12]
                    if (enc) begin
                        mapBus[`TXM_LO_CTL] = f[`TXM_F_CLO]; // [RL13]
                        mapBus[`TXM_HN_CTL] = f[`TXM_F_CHI]; // [RL13]
                        if (pipe) begin
                            mapBus[`TXM_LO_FRC] = complianceBit(f); // [RL15]
                            mapBus[`TXM_HN_FRC] = 1'b0; // [RL15]
                            mapBus[`TXM_LO_DSP] = f[`TXM_F_IDL]; // [RL16]
                            mapBus[`TXM_HN_DSP] = f[`TXM_F_IDL]; // [RL16]
                        end else begin
                            mapBus[`TXM_LO_FRC] = f[`TXM_F_FLO]; // [RL14]
                            mapBus[`TXM_HN_FRC] = f[`TXM_F_FHI]; // [RL14]
                            mapBus[`TXM_LO_DSP] = f[`TXM_F_VLO]; // [RL14]
                            mapBus[`TXM_HN_DSP] = f[`TXM_F_VHI]; // [RL14]
                        end
                    end
                end
            end
            `TXM_WID_20: begin
                mapBus[9:0] = f[`TXM_F_DLO +: 10];
                if (pcsWide) begin
                    mapBus[`TXM_HW_BASE +: 10] = f[`TXM_F_DHI +: 10]; // [RL17]
                end else begin
                    mapBus[`TXM_HN_BASE +: 10] = f[`TXM_F_DHI +: 10]; // [RL18]
                end
            end
            default: begin
                mapBus = {`TXM_BUS_W{1'b0}};
            end
        endcase
    end

    // compliance force travels in its own lane of the fifo word [RL4] [RL15]
    function complianceBit;
        input [`TXM_FW-1:0] w;
        begin
            complianceBit = w[`TXM_F_CMP];
        end
    endfunction

    // output stage and sent-word counter
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            txFull <= {`TXM_BUS_W{1'b0}};
            txValid <= 1'b0;
            sent_q <= 32'h00000000;
        end else begin
            if (loadStage) begin
                txFull <= mapBus;
                txValid <= 1'b1;
            end else if (txReady) begin
                txValid <= 1'b0;
                txFull <= {`TXM_BUS_W{1'b0}}; // idle bus reads zero [RL19]
            end
            if (txValid & txReady) begin
                sent_q <= sent_q + 32'h00000001;
            end
        end
    end

    // apb decode and read mux
    assign apbAccess = psel & penable;
    assign mapped = (paddr == `TXM_OFS_CTRL) | (paddr == `TXM_OFS_STAT) |
        (paddr == `TXM_OFS_CNT);
    always @* begin
        readVal = 32'h00000000;
        case (paddr)
            `TXM_OFS_CTRL: readVal = {27'h0000000, ctrl_q};
            `TXM_OFS_STAT: readVal = {24'h000000, txValid, ~wordReady, ~fifoValid,
                fifoLevel[4:0]};
            `TXM_OFS_CNT: readVal = sent_q;
            default: readVal = 32'h00000000;
        endcase
    end

    // apb slave: one wait state, write lands on the completing edge
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            ctrl_q <= `TXM_CTRL_RST;
        end else if (apbAccess & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h00000000 : readVal;
        end else begin
            if (apbAccess & pready & pwrite & (paddr == `TXM_OFS_CTRL)) begin
                ctrl_q <= pwdata[4:0];
            end
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end
endmodule // tx_fabric_bus_field_mapper

`default_nettype wire

//--- testbench/tx_bus_sink.sv
/* transmit bus sink model: captures every accepted bus word in order
   assumes mclk domain; stall and slow are set by the bench */
`timescale 1ns/1ps
`default_nettype none
module tx_bus_sink (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [43:0] txFull,
    input wire logic txValid,
    input wire logic stall,
    input wire logic slow,
    output logic txReady
);
    logic [43:0] got[$];
    // take a word on valid and ready, hold off while stalled, ready every other cycle while slow
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            txReady <= 1'h0;
        end else begin
            if (txValid && txReady) got.push_back(txFull);
            txReady <= !stall && !(slow && txReady);
        end
    end
endmodule // tx_bus_sink
`default_nettype wire

//--- testbench/tx_map_checker.sv
/* port checker for the field mapper: apb answers and transmit bus
   assumes bind onto the top module, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module tx_map_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wordValid,
    input wire logic wordReady,
    input wire logic [43:0] txFull,
    input wire logic txValid,
    input wire logic txReady
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // access phase still waiting for its answer
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    a_ready_next: assert property (s_acc |=> pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_ready_cause: assert property (!(psel && penable) |=> !pready) else $error("stray ready");
    a_err_addr: assert property (s_acc |=> pslverr == ($past(paddr) > 12'h008))
        else $error("bad error flag");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txFull))
        else $error("word dropped");
    a_idle_zero: assert property (!txValid |-> txFull == 44'h0)
        else $error("idle bus");
    a_top_zero: assert property (txFull[43:33] == 11'h0)
        else $error("top bits");
    a_word_soon: assert property (wordValid && wordReady && !txValid |-> ##[1:3] txValid)
        else $error("word stuck");
endmodule // tx_map_checker
bind tx_fabric_bus_field_mapper tx_map_checker tx_map_checker_inst (.mclk, .nrst, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .wordValid, .wordReady, .txFull, .txValid,
    .txReady);
`default_nettype wire

//--- testbench/test_tx_fabric_bus_field_mapper.sv
/* bench for the field mapper: registers, mapping table, fifo fill
   assumes the sink model and checker are compiled first */
`timescale 1ns/1ps
`default_nettype none
module test_tx_fabric_bus_field_mapper;
    logic mclk = '0, nrst = '0, psel = '0, penable = '0, pwrite = '0, wordValid = '0;
    logic ctrlLo = '0, ctrlHi = '0, forceDispLo = '0, forceDispHi = '0, dispValLo = '0;
    logic dispValHi = '0, complianceForce = '0, elecIdleForce = '0, stall = '0, slow = '0;
    logic pready, pslverr, wordReady, txValid, txReady, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [9:0] dataLo = '0, dataHi = '0;
    logic [43:0] txFull;
    logic [43:0] expQ[$];
    int failures = 0, checks = 0;
    // free running clock
    always #25 mclk = ~mclk;
    tx_fabric_bus_field_mapper tx_fabric_bus_field_mapper_inst (.mclk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wordValid, .wordReady, .dataLo,
        .dataHi, .ctrlLo, .ctrlHi, .forceDispLo, .forceDispHi, .dispValLo, .dispValHi,
        .complianceForce, .elecIdleForce, .txFull, .txValid, .txReady);
    tx_bus_sink tx_bus_sink_inst (.mclk, .nrst, .txFull, .txValid, .stall, .slow, .txReady);
    task report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task cmp44(input [43:0] g, input [43:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task cmp32(input [31:0] g, input [31:0] e);
        cmp44({12'h0, g}, {12'h0, e});
    endtask
    task tick(inout int n);
        if (++n > 60) begin
            failures++;
            report_and_stop;
        end
        @(posedge mclk);
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1) tick(n);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    // expected bus word; f holds compliance, idle, disparity values, force enables, control flags
    function [43:0] expMap(input [4:0] c, input [9:0] lo, hi, input [7:0] f);
        logic [43:0] m;
        m = '0;
        case (c[1:0])
            2'h0: begin
                m[7:0] = lo[7:0];
                if (c[3]) m[10:8] = {c[4] ? f[6] : f[4], c[4] ? f[7] : f[2], f[0]};
            end
            2'h1: m[9:0] = lo;
            2'h2: begin
                m[7:0] = lo[7:0];
                if (c[2]) m[18:11] = hi[7:0];
                else m[29:22] = hi[7:0];
                if (c[3] && c[2]) {m[21:19], m[10:8]} = {f[5], f[3], f[1], f[4], f[2], f[0]};
                if (c[3] && !c[2]) begin
                    {m[30], m[8], m[9]} = {f[1], f[0], c[4] ? f[7] : f[2]};
                    m[31] = c[4] ? 1'h0 : f[3];
                    {m[32], m[10]} = c[4] ? {2{f[6]}} : {f[5], f[4]};
                end
            end
            default: begin
                m[9:0] = lo;
                if (c[2]) m[20:11] = hi;
                else m[31:22] = hi;
            end
        endcase
        return m;
    endfunction
    // offer one fabric word and wait until it is taken
    task send(input [4:0] c, input [7:0] k);
        logic [9:0] lo;
        int n;
        n = 0;
        lo = {k[1:0], k} ^ 10'h2A5;
        dataLo <= lo;
        dataHi <= ~lo;
        {elecIdleForce, dispValHi, dispValLo, forceDispHi, forceDispLo, ctrlHi, ctrlLo} <= k[6:0];
        complianceForce <= k[7];
        wordValid <= 1'h1;
        expQ.push_back(expMap(c, lo, ~lo, k));
        @(posedge mclk);
        while (wordReady !== 1'h1) tick(n);
        wordValid <= 1'h0;
        @(posedge mclk);
    endtask
    task drain;
        int n;
        n = 0;
        while (tx_bus_sink_inst.got.size() < expQ.size()) tick(n);
        repeat (4) @(posedge mclk);
        cmp32(tx_bus_sink_inst.got.size(), expQ.size());
        foreach (expQ[i]) cmp44(tx_bus_sink_inst.got[i], expQ[i]);
        expQ.delete();
        tx_bus_sink_inst.got.delete();
    endtask
    task test_regs;
        apb(1'h0, 12'h000, 32'h0);
        cmp32(rd, 32'h0);
        apb(1'h1, 12'h004, 32'hFF);
        apb(1'h0, 12'h004, 32'h0);
        cmp32(rd, 32'h20);
        apb(1'h0, 12'h00C, 32'h0);
        cmp32({31'h0, er}, 32'h1);
        apb(1'h1, 12'h000, 32'h1F);
        apb(1'h0, 12'h000, 32'h0);
        cmp32(rd, 32'h1F);
        $display("test_regs done");
    endtask
    task test_maps;
        logic [4:0] cfg [10] = '{5'h00, 5'h08, 5'h18, 5'h01, 5'h0E, 5'h1E, 5'h0A, 5'h1A, 5'h07, 5'h03};
        foreach (cfg[i]) begin
            apb(1'h1, 12'h000, {27'h0, cfg[i]});
            slow <= i[0];
            send(cfg[i], 8'(i * 59));
            send(cfg[i], ~8'(i * 59));
            drain;
        end
        $display("test_maps done");
    endtask
    task test_fill;
        apb(1'h1, 12'h000, 32'h0A);
        stall <= 1'h1;
        slow <= 1'h0;
        for (int i = 0; i < 17; i++) send(5'h0A, 8'(i * 23));
        cmp32({31'h0, wordReady}, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        cmp32(rd, 32'hD0);
        wordValid <= 1'h1;
        repeat (3) @(posedge mclk);
        wordValid <= 1'h0;
        stall <= 1'h0;
        drain;
        apb(1'h0, 12'h008, 32'h0);
        cmp32(rd, 32'h25);
        $display("test_fill done");
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        test_regs;
        test_maps;
        test_fill;
        report_and_stop;
    end
endmodule // test_tx_fabric_bus_field_mapper
`default_nettype wire
